// ==== logic/irq_arbiter.sv ====
// Purpose: Pick the pending source to vector from level and fixed ranking
// Assumes: Inputs already gated by enables
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none

module irq_arbiter
	import irq_resp_pkg::*;
(
	// Requests
	input wire logic [3:0] req_i,
	input wire logic [7:0] lvl_i,
	input wire logic [2:0] floor_i,
	// Choice
	output logic found_o,
	output irq_src_t src_o,
	output logic [1:0] level_o
);

	always_comb begin
		found_o = 1'b0;
		src_o = SRC_TMR1;
		level_o = 2'h0;
		// Highest level first, lowest index wins ties
		for (int l = 3; l >= 0; l--) begin
			for (int s = 3; s >= 0; s--) begin
				if (!found_o && req_i[s] && lvl_i[2*s +: 2] == l[1:0] && {1'b0, l[1:0]} >= floor_i) begin
					src_o = irq_src_t'(s[1:0]);
					level_o = l[1:0];
				end
			end
			if (!found_o && level_o == l[1:0] && (req_i & lvl_mask(l[1:0])) != 4'h0
				&& {1'b0, l[1:0]} >= floor_i) begin
				found_o = 1'b1;
			end
		end
	end

	function automatic logic [3:0] lvl_mask(input logic [1:0] l);
		logic [3:0] m;
		m = 4'h0;
		for (int s = 0; s < 4; s++) begin
			m[s] = (lvl_i[2*s +: 2] == l);
		end
		return m;
	endfunction : lvl_mask

endmodule : irq_arbiter

`default_nettype wire

// ==== logic/irq_resp_pkg.sv ====
// Purpose: Types shared by the interrupt response block
// Assumes: Four sources, four priority levels
// Notes: Source index order is the fixed arbitration ranking
package irq_resp_pkg;

	typedef enum logic [1:0] {
		SRC_TMR1,
		SRC_UART,
		SRC_CMP,
		SRC_PWM
	} irq_src_t;

	typedef struct packed {
		logic pwm;
		logic cmp;
		logic uart;
		logic tmr1;
	} src_vec_t;

	typedef struct packed {
		logic valid;
		logic [15:0] vector;
		logic [1:0] level;
	} call_req_t;

endpackage : irq_resp_pkg

// ==== logic/irq_resp_regs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the interrupt response block
// Assumes: Wishbone classic slave, 32-bit data, word aligned registers
// Notes: Definitions only
`ifndef IRQ_RESP_REGS_SVH
`define IRQ_RESP_REGS_SVH

`define OFS_IRQ_ENABLE 6'h00
`define OFS_EXT_IRQ_EN 6'h04
`define OFS_PRIO0_LO 6'h08
`define OFS_PRIO0_HI 6'h0C
`define OFS_PRIO1_LO 6'h10
`define OFS_PRIO1_HI 6'h14
`define OFS_CMP_CTRL 6'h18
`define OFS_STATUS 6'h1C
`define OFS_MASK 6'h20
`define OFS_CORE_STATE 6'h24

`define BIT_GLOBAL_EN 7
`define BIT_CMP_EN 6
`define BIT_UART_EN 4
`define BIT_TMR1_EN 3
`define BIT_PWM_EN 5
`define BIT_CMP_LOW_POWER 5

`define RST_BYTE 8'h00

`define VEC_TMR1 16'h001B
`define VEC_UART 16'h0023
`define VEC_CMP 16'h0033
`define VEC_PWM 16'h006B

`define CLKS_PER_MCYC 4
`define PHASE_THREE 2'h2
`define CALL_MCYCLES 4
`define MAX_LAT_MCYCLES 12
`define MAX_LAT_CLKS (`MAX_LAT_MCYCLES * `CLKS_PER_MCYC)

`endif

// ==== logic/irq_response.sv ====
// Purpose: Interrupt request latching, polling, arbitration and hardware call
// Assumes: Core clock, four clocks per machine cycle, peripherals synchronous
// Notes: Wishbone classic slave for enables, priorities and interrupt status
// Overview of operation
// - Serial request inputs sampled once per machine cycle at phase three.
// - Timer 1 overflow flag set at phase three of the overflow cycle.
// - Latched flags polled only in the machine cycle after they were set.
// - Accepted request inserts a four machine cycle hardware call.
// - Pending request waits while equal or higher level handler runs.
// - Vectoring waits for the last machine cycle of the current instruction.
// - Latency from activation at most 12 machine cycles with no handler active.
// - Budget: 1 detect, 2 register access, 5 multiply or divide.
// - One machine cycle is four clocks; twelve machine cycles are 48 clocks.
// - Fixed vectors 001B, 0023, 0033 and 006B per source.
// - Ranking timer 1, serial, comparator, PWM; only timer 1 cleared by hardware.
// - Watchdog wakes power-down only when clocked from internal RC.
// - Comparator wakes only with low-power enable; others never wake.
// - Comparator request gated by bit 6 of the interrupt enable register.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irq_resp_regs.svh"

module irq_response
	import irq_resp_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Peripheral events
	input wire logic tmr1_ovf_i,
	input wire logic tx_done_i,
	input wire logic rx_done_i,
	input wire logic cmp_event_i,
	input wire logic pwm_under_i,
	input wire logic wdt_irq_i,
	input wire logic wdt_rc_clk_i,
	// CPU core
	input wire logic last_mcyc_i,
	input wire logic reti_i,
	input wire logic power_down_i,
	output call_req_t call_o,
	output logic call_busy_o,
	output logic wake_o,
	output logic irq_o
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PENDING,
		ST_CALL
	} state_t;

	state_t state_r;
	state_t state_nxt;
	logic [1:0] phase_r;
	logic [2:0] call_cnt_r;
	logic [7:0] ie_r;
	logic [7:0] eie_r;
	logic [7:0] p0lo_r;
	logic [7:0] p0hi_r;
	logic [7:0] p1lo_r;
	logic [7:0] p1hi_r;
	logic [7:0] cmpc_r;
	logic [7:0] mask_r;
	src_vec_t flag_r;
	src_vec_t polled_r;
	logic tx_done_flag_r;
	logic rx_done_flag_r;
	logic [7:0] stat_r;
	logic [3:0] active_r;
	logic [1:0] active_lvl_r [4];
	call_req_t call_r;
	irq_src_t sel_src_r;
	logic ack_r;
	logic [31:0] dat_r;

	// Bus decode
	wire logic acc = cyc_i && stb_i && !ack_r;
	// Writes land on the edge at which the master samples ack high
	wire logic wr = cyc_i && stb_i && ack_r && we_i && sel_i[0];
	wire logic wr_ie = wr && adr_i == `OFS_IRQ_ENABLE;
	wire logic wr_eie = wr && adr_i == `OFS_EXT_IRQ_EN;
	wire logic wr_p0lo = wr && adr_i == `OFS_PRIO0_LO;
	wire logic wr_p0hi = wr && adr_i == `OFS_PRIO0_HI;
	wire logic wr_p1lo = wr && adr_i == `OFS_PRIO1_LO;
	wire logic wr_p1hi = wr && adr_i == `OFS_PRIO1_HI;
	wire logic wr_cmpc = wr && adr_i == `OFS_CMP_CTRL;
	wire logic wr_stat = wr && adr_i == `OFS_STATUS;
	wire logic wr_mask = wr && adr_i == `OFS_MASK;
	wire logic [7:0] wbyte = dat_i[7:0];

	// Machine cycle timing
	wire logic at_phase_three = phase_r == `PHASE_THREE;
	wire logic mcyc_end = phase_r == 2'(`CLKS_PER_MCYC - 1);

	// Source enables and levels
	wire logic gen = ie_r[`BIT_GLOBAL_EN];
	wire logic [3:0] en_vec = {eie_r[`BIT_PWM_EN], ie_r[`BIT_CMP_EN], ie_r[`BIT_UART_EN], ie_r[`BIT_TMR1_EN]};
	wire logic [1:0] lvl_tmr1 = {p0hi_r[3], p0lo_r[3]};
	wire logic [1:0] lvl_uart = {p0hi_r[4], p0lo_r[4]};
	wire logic [1:0] lvl_cmp = {p0hi_r[6], p0lo_r[6]};
	wire logic [1:0] lvl_pwm = {p1hi_r[5], p1lo_r[5]};
	wire logic [7:0] lvl_vec = {lvl_pwm, lvl_cmp, lvl_uart, lvl_tmr1};
	wire logic [3:0] req_vec = gen ? (polled_r & en_vec) : 4'h0;

	// Lowest level allowed to preempt: one above the highest in service
	function automatic logic [2:0] floor_of(input logic [3:0] act, input logic [7:0] lv);
		logic [2:0] f;
		f = 3'h0;
		for (int s = 0; s < 4; s++) begin
			if (act[s] && {1'b0, lv[2*s +: 2]} + 3'h1 > f) begin
				f = {1'b0, lv[2*s +: 2]} + 3'h1;
			end
		end
		return f;
	endfunction : floor_of

	function automatic logic [15:0] vec_of(input irq_src_t s);
		logic [15:0] v;
		unique case (s)
			SRC_TMR1: v = `VEC_TMR1;
			SRC_UART: v = `VEC_UART;
			SRC_CMP: v = `VEC_CMP;
			SRC_PWM: v = `VEC_PWM;
		endcase
		return v;
	endfunction : vec_of

	logic [2:0] active_lvl_flat_floor;
	assign active_lvl_flat_floor = floor_of(active_r, {active_lvl_r[3], active_lvl_r[2], active_lvl_r[1], active_lvl_r[0]});

	logic found;
	irq_src_t win_src;
	logic [1:0] win_lvl;

	irq_arbiter i_irq_arbiter (
		.req_i(req_vec),
		.lvl_i(lvl_vec),
		.floor_i(active_lvl_flat_floor),
		.found_o(found),
		.src_o(win_src),
		.level_o(win_lvl)
	);

	// Worst case waits out a five machine cycle instruction, inside the twelve cycle budget
	// Request may only be vectored at the end of the last machine cycle
	wire logic take = state_r == ST_PENDING && found && mcyc_end && last_mcyc_i;
	wire logic call_done = state_r == ST_CALL && mcyc_end && call_cnt_r == 3'(`CALL_MCYCLES - 1);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: if (mcyc_end && req_vec != 4'h0) state_nxt = ST_PENDING;
			ST_PENDING: begin
				if (take) state_nxt = ST_CALL;
				else if (req_vec == 4'h0) state_nxt = ST_IDLE;
			end
			ST_CALL: if (call_done) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Timer 1 flag cleared by hardware on its own vectoring
	wire logic hw_clr_tmr1 = take && win_src == SRC_TMR1;
	wire logic [3:0] evt = {pwm_under_i, cmp_event_i, tx_done_i | rx_done_i, tmr1_ovf_i};
	wire logic [3:0] sw_clr = wr_stat ? wbyte[3:0] : 4'h0;
	wire logic [3:0] hw_clr = {3'h0, hw_clr_tmr1};

	// Next flag values; each set term beats a same-cycle clear
	wire logic tmr1_flag_nxt = (at_phase_three && tmr1_ovf_i) || (flag_r.tmr1 && !sw_clr[0] && !hw_clr_tmr1);
	wire logic uart_flag_nxt = (at_phase_three && (tx_done_i || rx_done_i)) || (flag_r.uart && !sw_clr[1]);
	wire logic cmp_flag_nxt = (at_phase_three && cmp_event_i) || (flag_r.cmp && !sw_clr[2]);
	wire logic pwm_under_flag_nxt = (at_phase_three && pwm_under_i) || (flag_r.pwm && !sw_clr[3]);
	wire logic tx_done_flag_nxt = (at_phase_three && tx_done_i) || (tx_done_flag_r && !sw_clr[1]);
	wire logic rx_done_flag_nxt = (at_phase_three && rx_done_i) || (rx_done_flag_r && !sw_clr[1]);
	wire logic [3:0] flag_nxt = {pwm_under_flag_nxt, cmp_flag_nxt, uart_flag_nxt, tmr1_flag_nxt};

	// Core clock phase counter
	always_ff @(posedge clk_i) begin
		if (rst_i) phase_r <= 2'h0;
		else phase_r <= phase_r + 2'h1;
	end

	// Flags set only at the phase three edge
	always_ff @(posedge clk_i) begin
		if (rst_i) flag_r <= '0;
		else flag_r <= flag_nxt;
	end

	// Serial cause bits kept apart so software can tell transmit from receive
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_done_flag_r <= 1'b0;
			rx_done_flag_r <= 1'b0;
		end else begin
			tx_done_flag_r <= tx_done_flag_nxt;
			rx_done_flag_r <= rx_done_flag_nxt;
		end
	end

	// Snapshot at machine cycle end so polling sees last cycle's flags
	always_ff @(posedge clk_i) begin
		if (rst_i) polled_r <= '0;
		else if (mcyc_end) polled_r <= flag_r & ~hw_clr;
		else if (hw_clr_tmr1) polled_r.tmr1 <= 1'b0;
	end

	// Vector and level captured at the take edge stand for the whole call
	call_req_t call_nxt;
	always_comb begin
		call_nxt = call_r;
		if (take) call_nxt = '{valid: 1'b1, vector: vec_of(win_src), level: win_lvl};
		else if (call_done) call_nxt.valid = 1'b0;
	end

	// Vectoring state machine and call counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			call_cnt_r <= 3'h0;
			call_r <= '0;
			sel_src_r <= SRC_TMR1;
		end else begin
			state_r <= state_nxt;
			call_r <= call_nxt;
			if (take) begin
				call_cnt_r <= 3'h0;
				sel_src_r <= win_src;
			end else if (state_r == ST_CALL && mcyc_end && !call_done) begin
				call_cnt_r <= call_cnt_r + 3'h1;
			end
		end
	end

	// In-service tracking; return ends the highest level handler
	// Procedural so that a change of the stored levels also re-evaluates
	logic [3:0] top_active;
	always_comb top_active = top_of(active_r);
	function automatic logic [3:0] top_of(input logic [3:0] act);
		logic [3:0] t;
		logic [2:0] best;
		t = 4'h0;
		best = 3'h0;
		for (int s = 0; s < 4; s++) begin
			if (act[s] && {1'b0, active_lvl_r[s]} + 3'h1 > best) begin
				best = {1'b0, active_lvl_r[s]} + 3'h1;
				t = 4'h1 << s;
			end
		end
		return t;
	endfunction : top_of

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_r <= 4'h0;
			for (int s = 0; s < 4; s++) active_lvl_r[s] <= 2'h0;
		end else if (call_done) begin
			active_r[sel_src_r] <= 1'b1;
			active_lvl_r[sel_src_r] <= call_r.level;
		end else if (reti_i) begin
			active_r <= active_r & ~top_active;
		end
	end

	// Interrupt-style status: sticky event bits, write one to clear, set wins
	wire logic [7:0] stat_nxt = {4'h0, evt} | (stat_r & ~(wr_stat ? wbyte : 8'h00));
	always_ff @(posedge clk_i) begin
		if (rst_i) stat_r <= `RST_BYTE;
		else stat_r <= stat_nxt;
	end

	// Register file
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ie_r <= `RST_BYTE;
			eie_r <= `RST_BYTE;
			p0lo_r <= `RST_BYTE;
			p0hi_r <= `RST_BYTE;
			p1lo_r <= `RST_BYTE;
			p1hi_r <= `RST_BYTE;
			cmpc_r <= `RST_BYTE;
			mask_r <= `RST_BYTE;
		end else begin
			if (wr_ie) ie_r <= wbyte;
			if (wr_eie) eie_r <= wbyte;
			if (wr_p0lo) p0lo_r <= wbyte;
			if (wr_p0hi) p0hi_r <= wbyte;
			if (wr_p1lo) p1lo_r <= wbyte;
			if (wr_p1hi) p1hi_r <= wbyte;
			if (wr_cmpc) cmpc_r <= {2'b00, wbyte[5:0]};
			if (wr_mask) mask_r <= wbyte;
		end
	end

	// Read mux; unmapped addresses read zero and still acknowledge
	logic [7:0] rd_byte;
	always_comb begin
		unique case (adr_i)
			`OFS_IRQ_ENABLE: rd_byte = ie_r;
			`OFS_EXT_IRQ_EN: rd_byte = eie_r;
			`OFS_PRIO0_LO: rd_byte = p0lo_r;
			`OFS_PRIO0_HI: rd_byte = p0hi_r;
			`OFS_PRIO1_LO: rd_byte = p1lo_r;
			`OFS_PRIO1_HI: rd_byte = p1hi_r;
			`OFS_CMP_CTRL: rd_byte = cmpc_r;
			`OFS_STATUS: rd_byte = stat_r;
			`OFS_MASK: rd_byte = mask_r;
			`OFS_CORE_STATE: rd_byte = {tx_done_flag_r, rx_done_flag_r, state_r, flag_r};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= acc;
			if (acc && !we_i) dat_r <= {24'h000000, rd_byte};
		end
	end

	// Wake: comparator only with low-power enable, watchdog only on RC clock
	wire logic wake_cmp = flag_r.cmp && ie_r[`BIT_CMP_EN] && cmpc_r[`BIT_CMP_LOW_POWER];
	wire logic wake_wdt = wdt_irq_i && wdt_rc_clk_i;

	assign dat_o = dat_r;
	assign ack_o = ack_r;
	assign call_o = call_r;
	assign call_busy_o = state_r == ST_CALL;
	assign wake_o = power_down_i && (wake_cmp || wake_wdt);
	assign irq_o = (stat_r & mask_r) != 8'h00;

endmodule : irq_response

`default_nettype wire

// ==== tb/core_model.sv ====
// Purpose: CPU core model: instruction boundaries and handler returns
// Assumes: Counters aligned with the block's phase after reset
// Notes: Handler runs eight clocks after the call; hold keeps it running
`timescale 1ns/1ps
`default_nettype none

module core_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bench control
	input wire logic long_instr_i,
	input wire logic hold_i,
	// Block side
	input wire logic call_valid_i,
	output logic last_mcyc_o,
	output logic reti_o
);
	logic [4:0] instr_cnt_r;
	logic [4:0] svc_cnt_r;
	logic in_svc_r;
	// Multiply takes five machine cycles; only its last one ends the instruction
	assign last_mcyc_o = !long_instr_i || (instr_cnt_r >= 5'h10);
	always_ff @(posedge clk_i) begin
		if (rst_i || instr_cnt_r == 5'h13) instr_cnt_r <= 5'h0;
		else instr_cnt_r <= instr_cnt_r + 5'h1;
	end
	always_ff @(posedge clk_i) begin
		reti_o <= 1'b0;
		if (rst_i) begin
			in_svc_r <= 1'b0;
			svc_cnt_r <= 5'h0;
		end else if (call_valid_i) begin
			in_svc_r <= 1'b1;
			svc_cnt_r <= 5'h0;
		end else if (in_svc_r && !hold_i) begin
			svc_cnt_r <= svc_cnt_r + 5'h1;
			if (svc_cnt_r == 5'h07) begin
				reti_o <= 1'b1;
				in_svc_r <= 1'b0;
			end
		end
	end
endmodule : core_model

`default_nettype wire

// ==== tb/interrupt_response_logic_test.sv ====
// Purpose: Self-checking bench of the interrupt response block
// Assumes: Core model drives the CPU side; bench drives bus and events
// Notes: Events stand one machine cycle so the phase three sample is sure
`timescale 1ns/1ps
`default_nettype none
`include "irq_resp_regs.svh"

module interrupt_response_logic_test
	import irq_resp_pkg::*;
;
	typedef struct packed {logic [4:0] ev; logic lng; logic [15:0] vec;} row_t;
	row_t rows [6] = '{'{5'h01, 1'b0, `VEC_TMR1}, '{5'h02, 1'b0, `VEC_UART}, '{5'h04, 1'b0, `VEC_UART},
		'{5'h08, 1'b0, `VEC_CMP}, '{5'h10, 1'b0, `VEC_PWM}, '{5'h01, 1'b1, `VEC_TMR1}};
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [5:0] adr_i = 6'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic [4:0] ev = 5'h00;
	logic ack_o, call_busy_o, wake_o, irq_o, last_mcyc, reti, lng = 1'b0, hold = 1'b0;
	logic wdt_irq = 1'b0, wdt_rc = 1'b0, pd = 1'b0;
	call_req_t call_o;
	int failures = 0, check_count = 0, cycles = 0, lat;

	irq_response i_irq_response (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.tmr1_ovf_i(ev[0]), .tx_done_i(ev[1]), .rx_done_i(ev[2]), .cmp_event_i(ev[3]), .pwm_under_i(ev[4]),
		.wdt_irq_i(wdt_irq), .wdt_rc_clk_i(wdt_rc), .last_mcyc_i(last_mcyc), .reti_i(reti),
		.power_down_i(pd), .call_o, .call_busy_o, .wake_o, .irq_o);
	core_model i_core_model (.clk_i, .rst_i, .long_instr_i(lng), .hold_i(hold), .call_valid_i(call_o.valid),
		.last_mcyc_o(last_mcyc), .reti_o(reti));

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	task automatic test_done();
		if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			test_done();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Holds the request until the edge that samples ack; the global timeout bounds the wait
	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hF, d};
		@(posedge clk_i iff ack_o === 1'b1);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'b00;
	endtask : wb

	task automatic fire(input logic [4:0] m, input int lim);
		@(posedge clk_i);
		ev <= m;
		lat = 0;
		// The event always stands four clocks, even when a call is already showing
		while ((call_o.valid !== 1'b1 || lat < 4) && lat < lim) begin
			@(posedge clk_i);
			lat++;
			if (lat == 4) ev <= 5'h00;
		end
	endtask : fire

	task automatic settle();
		wb(1'b1, `OFS_STATUS, 32'h0F);
		repeat (40) @(posedge clk_i);
	endtask : settle

	task automatic reset_and_check();
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `OFS_IRQ_ENABLE, 32'h0);
		chk("ie_reset", 32'h0, rd);
		chk("outs_reset", 32'h0, {call_o.valid, irq_o, wake_o});
	endtask : reset_and_check

	initial begin
		reset_and_check();
		wb(1'b0, 6'h3C, 32'h0);
		chk("unmapped", 32'h0, rd);
		wb(1'b1, `OFS_IRQ_ENABLE, 32'hD8);
		wb(1'b1, `OFS_EXT_IRQ_EN, 32'h20);
		wb(1'b1, `OFS_MASK, 32'h0F);
		wb(1'b0, `OFS_IRQ_ENABLE, 32'h0);
		chk("ie", 32'hD8, rd);
		foreach (rows[i]) begin
			lng <= rows[i].lng;
			fire(rows[i].ev, 100);
			chk("latency", 32'h1, 32'(lat >= 8 && lat <= `MAX_LAT_CLKS));
			chk("vector", 32'(rows[i].vec), 32'(call_o.vector));
			chk("irq_o", 32'h1, 32'(irq_o));
			settle();
			chk("irq_clr", 32'h0, 32'(irq_o));
		end
		lng <= 1'b0;
		fire(5'h09, 100);
		chk("tie_first", 32'(`VEC_TMR1), 32'(call_o.vector));
		repeat (20) @(posedge clk_i);
		fire(5'h00, 100);
		chk("tie_second", 32'(`VEC_CMP), 32'(call_o.vector));
		settle();
		wb(1'b1, `OFS_PRIO0_LO, 32'h10);
		wb(1'b1, `OFS_PRIO0_HI, 32'h10);
		hold <= 1'b1;
		fire(5'h03, 100);
		chk("level_first", 32'(`VEC_UART), 32'(call_o.vector));
		chk("level_out", 32'h3, 32'(call_o.level));
		repeat (20) @(posedge clk_i);
		fire(5'h00, 60);
		chk("wait_handler", 32'h0, 32'(call_o.valid));
		wb(1'b1, `OFS_STATUS, 32'h02);
		hold <= 1'b0;
		fire(5'h00, 100);
		chk("after_reti", 32'(`VEC_TMR1), 32'(call_o.vector));
		settle();
		wb(1'b1, `OFS_IRQ_ENABLE, 32'h98);
		fire(5'h08, 60);
		chk("cmp_gated", 32'h0, 32'(call_o.valid));
		settle();
		wb(1'b1, `OFS_IRQ_ENABLE, 32'hD8);
		wb(1'b1, `OFS_CMP_CTRL, 32'h20);
		{pd, wdt_irq} <= 2'b11;
		repeat (2) @(posedge clk_i);
		chk("wdt_no_rc", 32'h0, 32'(wake_o));
		wdt_rc <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("wdt_rc", 32'h1, 32'(wake_o));
		{wdt_irq, wdt_rc} <= 2'b00;
		fire(5'h01, 12);
		chk("tmr1_wake", 32'h0, 32'(wake_o));
		fire(5'h08, 12);
		repeat (2) @(posedge clk_i);
		chk("cmp_wake", 32'h1, 32'(wake_o));
		wb(1'b1, `OFS_MASK, 32'h00);
		repeat (2) @(posedge clk_i);
		chk("irq_masked", 32'h0, 32'(irq_o));
		wb(1'b1, `OFS_MASK, 32'h0F);
		repeat (2) @(posedge clk_i);
		chk("irq_unmasked", 32'h1, 32'(irq_o));
		pd <= 1'b0;
		settle();
		chk("wake_off", 32'h0, 32'(wake_o));
		reset_and_check();
		test_done();
	end
endmodule : interrupt_response_logic_test

`default_nettype wire

// ==== tb/irq_response_sva.sv ====
// Purpose: Port-level checks of the interrupt response block
// Assumes: One clock domain, synchronous active-high reset
// Notes: Phase count mirrors the design's restart at zero on reset release
`timescale 1ns/1ps
`default_nettype none
`include "irq_resp_regs.svh"

module irq_response_sva
	import irq_resp_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// Events and core
	input wire logic wdt_irq_i,
	input wire logic wdt_rc_clk_i,
	input wire logic last_mcyc_i,
	input wire logic power_down_i,
	input wire call_req_t call_o,
	input wire logic call_busy_o,
	input wire logic wake_o
);
	logic [1:0] phase_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) phase_r <= 2'h0;
		else phase_r <= phase_r + 2'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_ANSWER: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	AST_CALL_LEN: assert property ($rose(call_o.valid) |-> call_o.valid [*8] ##1 call_o.valid [*8]
		##1 !call_o.valid) else $error("call not four machine cycles long");
	AST_CALL_BUSY: assert property (call_o.valid |-> call_busy_o) else $error("busy low during call");
	AST_CALL_LAST: assert property ($rose(call_o.valid) |-> $past(last_mcyc_i)) else $error("call mid instruction");
	AST_MCYC_ALIGN: assert property ($rose(call_o.valid) |-> phase_r == 2'h0) else $error("call off cycle edge");
	AST_VEC_SET: assert property (call_o.valid |->
		call_o.vector inside {`VEC_TMR1, `VEC_UART, `VEC_CMP, `VEC_PWM}) else $error("unknown vector");
	AST_VEC_HOLD: assert property (call_o.valid && $past(call_o.valid) |-> $stable(call_o.vector))
		else $error("vector changed in call");
	AST_WAKE_WDT: assert property (power_down_i && wdt_irq_i && wdt_rc_clk_i |-> wake_o)
		else $error("watchdog did not wake");
	AST_WAKE_PD: assert property (wake_o |-> power_down_i) else $error("wake outside power-down");
endmodule : irq_response_sva

bind irq_response irq_response_sva i_irq_response_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .wdt_irq_i,
	.wdt_rc_clk_i, .last_mcyc_i, .power_down_i, .call_o, .call_busy_o, .wake_o);

`default_nettype wire
